// [rtl/icp_pkg.sv]
// Shared constants for the serial configuration port with memory access.
// Assumes a single target on the bus and byte-wide registers.
package icp_pkg;
  localparam logic [6:0] OWN_ADDR = 7'h59;
  localparam logic [7:0] OFS_PCOUNT = 8'h30;
  localparam logic [7:0] OFS_MCTL = 8'h31;
  localparam logic [7:0] OFS_MADDR = 8'h33;
  localparam logic [7:0] OFS_EEDATA = 8'h34;
  localparam logic [7:0] OFS_SRDATA = 8'h35;
  localparam logic [7:0] OFS_UNLOCK = 8'h38;
  localparam int MCTL_COPY = 6;
  localparam int MCTL_BUSY = 2;
  localparam int MCTL_PROG = 0;
  localparam logic [7:0] MCTL_WMASK = 8'hBA;
  localparam logic [7:0] UNLOCK_KEY = 8'hBE;
  localparam logic [7:0] LOCK_VAL = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int STD_KHZ = 100;
  localparam int FAST_KHZ = 1000;
  localparam int GLITCH_NS = 50;
  localparam int REF_PERIOD_NS = 40;
  localparam logic [1:0] GLITCH_CYC = 2'((GLITCH_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
  localparam int PROG_CYC_DEF = 256;
  localparam int MEM_N_DEF = 64;
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_PACK, ST_WDATA, ST_RDATA, ST_RACK
  } icp_state_e;
endpackage

// [rtl/icp_target.sv]
// Serial target port: register file, shadow SRAM, EEPROM and program timer.
// Assumes open-drain pads outside; nvm_clk free-running for the program timer.
//
// Behaviour
// - Works at 100 kHz and 1 MHz clocks.
// - Pulses under 50 ns on lines ignored.
// - Respond only to address 1011001.
// - Data changes only while clock low.
// - Detect START and STOP conditions.
// - Eight bits, MSB first, then acknowledge slot.
// - Receiver pulls data low on ninth pulse.
// - Acknowledge address byte only when matching.
// - Master not-acknowledge ends read, go idle.
// - Write: address, pointer, data bytes, STOP.
// - Pointer advances after every data byte.
// - Read: pointer write, repeated START, read.
// - Control bit 6 copies registers to SRAM.
// - Pointer then SRAM data writes, auto-increment.
// - Busy bit set, EEPROM hidden while programming.
// - Unlock key then control bit 0 programs.
// - Program count increments per finished cycle.
// - SRAM reads auto-increment within transaction.
// - EEPROM reads auto-increment within transaction.
// - EEPROM loads registers after power-up.
// - Writes leave read-only bits unchanged.
`timescale 1ns/1ps
module icp_target #(
  parameter int MEM_N = icp_pkg::MEM_N_DEF,
  parameter int unsigned PROG_CYC = icp_pkg::PROG_CYC_DEF
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic nvm_clk,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic boot_done
);
  localparam int MW = $clog2(MEM_N);
  localparam logic [7:0] MEM_TOP = 8'(MEM_N);

  logic [1:0] lin, filt, sy3;
  logic scl_q, sda_q, scl_rise, scl_fall, start_det, stop_det;
  icp_pkg::icp_state_e state;
  logic [3:0] bitcnt;
  logic [7:0] shreg, txreg, ptr, wr_addr, wr_data, rd_addr, rd_val;
  logic rw, wr_stb, rd_stb, end_stb, booted;
  logic [7:0] regs [256];
  logic [7:0] sram [MEM_N];
  logic [7:0] eeprom [MEM_N];
  logic [7:0] mctl, unlock, mem_addr, prog_count, ee_view, sr_view;
  logic mem_open, prog_busy, req_tgl, d1, d2, d3, done_ev, wr_spec;
  logic n1, n2, n3, run, done_tgl;
  logic [15:0] pcnt;

  assign lin = {sda_i, scl_i};

  // Three-stage sync, then a level must persist past the glitch window
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_in
      logic s1, s2, s3, f;
      logic [1:0] c;
      always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          s3 <= 1'b1;
          f <= 1'b1;
          c <= 2'h0;
        end else begin
          s1 <= lin[gi];
          s2 <= s1;
          s3 <= s2;
          if (s3 != f && s2 == s3) begin
            if (c == icp_pkg::GLITCH_CYC - 2'h1) begin
              f <= s3;
              c <= 2'h0;
            end else begin
              c <= c + 2'h1;
            end
          end else begin
            c <= 2'h0;
          end
        end
      end
      assign filt[gi] = f;
      assign sy3[gi] = s3;
    end
  endgenerate

  // Previous filtered levels for edge and condition detection
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= filt[0];
      sda_q <= filt[1];
    end
  end

  // Filter delay is equal on both lines, so bit order and setup survive at 1 MHz
  assign scl_rise = filt[0] & ~scl_q;
  assign scl_fall = ~filt[0] & scl_q;
  assign start_det = scl_q & filt[0] & sda_q & ~filt[1];
  assign stop_det = scl_q & filt[0] & ~sda_q & filt[1];

  // Protocol engine; sda_oe moves on a clock fall, or is released at START or STOP
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= icp_pkg::ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= icp_pkg::RST_BYTE;
      txreg <= icp_pkg::RST_BYTE;
      ptr <= icp_pkg::RST_BYTE;
      rw <= 1'b0;
      sda_oe <= 1'b0;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      end_stb <= 1'b0;
      wr_addr <= icp_pkg::RST_BYTE;
      wr_data <= icp_pkg::RST_BYTE;
      rd_addr <= icp_pkg::RST_BYTE;
    end else begin
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      end_stb <= 1'b0;
      if (stop_det) begin
        state <= icp_pkg::ST_IDLE;
        sda_oe <= 1'b0;
        end_stb <= 1'b1;
      end else if (start_det) begin
        state <= icp_pkg::ST_ADDR;
        bitcnt <= 4'h0;
        sda_oe <= 1'b0;
      end else begin
        if (scl_rise) begin
          shreg <= {shreg[6:0], filt[1]};
          bitcnt <= bitcnt + 4'h1;
        end
        case (state)
          icp_pkg::ST_ADDR: begin
            if (scl_fall && bitcnt == icp_pkg::BITS_PER_BYTE) begin
              if (shreg[7:1] == icp_pkg::OWN_ADDR && booted) begin
                sda_oe <= 1'b1;
                rw <= shreg[0];
                state <= icp_pkg::ST_AACK;
              end else begin
                state <= icp_pkg::ST_IDLE;
              end
            end
          end
          icp_pkg::ST_AACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              if (rw) begin
                txreg <= rd_val;
                sda_oe <= ~rd_val[7];
                rd_stb <= 1'b1;
                rd_addr <= ptr;
                ptr <= ptr + icp_pkg::BYTE_ONE;
                state <= icp_pkg::ST_RDATA;
              end else begin
                sda_oe <= 1'b0;
                state <= icp_pkg::ST_PTR;
              end
            end
          end
          icp_pkg::ST_PTR: begin
            if (scl_fall && bitcnt == icp_pkg::BITS_PER_BYTE) begin
              ptr <= shreg;
              sda_oe <= 1'b1;
              state <= icp_pkg::ST_PACK;
            end
          end
          icp_pkg::ST_PACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              bitcnt <= 4'h0;
              state <= icp_pkg::ST_WDATA;
            end
          end
          icp_pkg::ST_WDATA: begin
            if (scl_fall && bitcnt == icp_pkg::BITS_PER_BYTE) begin
              wr_stb <= 1'b1;
              wr_addr <= ptr;
              wr_data <= shreg;
              ptr <= ptr + icp_pkg::BYTE_ONE;
              sda_oe <= 1'b1;
              state <= icp_pkg::ST_PACK;
            end
          end
          icp_pkg::ST_RDATA: begin
            if (scl_fall) begin
              if (bitcnt == icp_pkg::BITS_PER_BYTE) begin
                sda_oe <= 1'b0;
                state <= icp_pkg::ST_RACK;
              end else begin
                txreg <= {txreg[6:0], 1'b0};
                sda_oe <= ~txreg[6];
              end
            end
          end
          icp_pkg::ST_RACK: begin
            if (scl_rise) begin
              if (filt[1]) begin
                state <= icp_pkg::ST_IDLE;
              end else begin
                state <= icp_pkg::ST_AACK;
              end
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Read view; busy hides the EEPROM and out-of-range memory reads zero
  assign ee_view = (prog_busy || mem_addr >= MEM_TOP) ? icp_pkg::RST_BYTE :
                   eeprom[mem_addr[MW-1:0]];
  assign sr_view = (mem_addr >= MEM_TOP) ? icp_pkg::RST_BYTE : sram[mem_addr[MW-1:0]];

  always_comb begin
    rd_val = regs[ptr];
    wr_spec = 1'b1;
    case (ptr)
      icp_pkg::OFS_PCOUNT: rd_val = prog_count;
      icp_pkg::OFS_MCTL: begin
        rd_val = mctl;
        rd_val[icp_pkg::MCTL_BUSY] = prog_busy;
      end
      icp_pkg::OFS_MADDR: rd_val = mem_addr;
      icp_pkg::OFS_EEDATA: rd_val = ee_view;
      icp_pkg::OFS_SRDATA: rd_val = sr_view;
      icp_pkg::OFS_UNLOCK: rd_val = unlock;
      default: ;
    endcase
    case (wr_addr)
      icp_pkg::OFS_PCOUNT, icp_pkg::OFS_MCTL, icp_pkg::OFS_MADDR,
      icp_pkg::OFS_EEDATA, icp_pkg::OFS_SRDATA, icp_pkg::OFS_UNLOCK: wr_spec = 1'b1;
      default: wr_spec = 1'b0;
    endcase
  end

  // Boot flag; the port refuses its address until the load is done
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      booted <= 1'b0;
      boot_done <= 1'b0;
      sda_o <= 1'b0;
    end else begin
      booted <= 1'b1;
      boot_done <= booted;
      sda_o <= 1'b0;
    end
  end

  // Working registers: one-cycle load from EEPROM, then serial writes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 256; i++) begin
        regs[i] <= icp_pkg::RST_BYTE;
      end
    end else if (!booted) begin
      for (int i = 0; i < MEM_N; i++) begin
        regs[i] <= eeprom[i];
      end
    end else if (wr_stb && !wr_spec) begin
      regs[wr_addr] <= wr_data;
    end
  end

  // Memory control, pointer and program launch; completion wins over nothing
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mctl <= icp_pkg::RST_BYTE;
      unlock <= icp_pkg::LOCK_VAL;
      mem_addr <= icp_pkg::RST_BYTE;
      mem_open <= 1'b0;
      prog_busy <= 1'b0;
      prog_count <= icp_pkg::RST_BYTE;
      req_tgl <= 1'b0;
    end else begin
      if (done_ev) begin
        prog_busy <= 1'b0;
        prog_count <= prog_count + icp_pkg::BYTE_ONE;
      end
      if (end_stb) begin
        mem_open <= 1'b0;
      end
      if (wr_stb) begin
        case (wr_addr)
          icp_pkg::OFS_MCTL: begin
            mctl <= wr_data & icp_pkg::MCTL_WMASK;
            if (wr_data[icp_pkg::MCTL_PROG] && unlock == icp_pkg::UNLOCK_KEY &&
                !prog_busy) begin
              prog_busy <= 1'b1;
              req_tgl <= ~req_tgl;
            end
          end
          icp_pkg::OFS_MADDR: begin
            mem_addr <= wr_data;
            mem_open <= 1'b1;
          end
          icp_pkg::OFS_SRDATA: begin
            if (mem_open) begin
              mem_addr <= mem_addr + icp_pkg::BYTE_ONE;
            end
          end
          icp_pkg::OFS_UNLOCK: unlock <= wr_data;
          default: ;
        endcase
      end
      if (rd_stb && mem_open && (rd_addr == icp_pkg::OFS_SRDATA ||
          (rd_addr == icp_pkg::OFS_EEDATA && !prog_busy))) begin
        mem_addr <= mem_addr + icp_pkg::BYTE_ONE;
      end
    end
  end

  // Shadow SRAM; frozen while the EEPROM copies it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < MEM_N; i++) begin
        sram[i] <= icp_pkg::RST_BYTE;
      end
    end else if (!prog_busy && wr_stb) begin
      if (wr_addr == icp_pkg::OFS_MCTL && wr_data[icp_pkg::MCTL_COPY]) begin
        for (int i = 0; i < MEM_N; i++) begin
          sram[i] <= regs[i];
        end
      end else if (wr_addr == icp_pkg::OFS_SRDATA && mem_open && mem_addr < MEM_TOP) begin
        sram[mem_addr[MW-1:0]] <= wr_data;
      end
    end
  end

  // EEPROM array takes the SRAM image when the program timer finishes
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < MEM_N; i++) begin
        eeprom[i] <= icp_pkg::RST_BYTE;
      end
    end else if (done_ev) begin
      for (int i = 0; i < MEM_N; i++) begin
        eeprom[i] <= sram[i];
      end
    end
  end

  // Done toggle back from the program timer domain
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      d1 <= 1'b0;
      d2 <= 1'b0;
      d3 <= 1'b0;
    end else begin
      d1 <= done_tgl;
      d2 <= d1;
      d3 <= d2;
    end
  end
  assign done_ev = d2 ^ d3;

  // Program timer on nvm_clk; SRAM stays frozen while it runs
  always_ff @(posedge nvm_clk or negedge rstn) begin
    if (!rstn) begin
      n1 <= 1'b0;
      n2 <= 1'b0;
      n3 <= 1'b0;
      run <= 1'b0;
      pcnt <= 16'h0000;
      done_tgl <= 1'b0;
    end else begin
      n1 <= req_tgl;
      n2 <= n1;
      n3 <= n2;
      if (n2 ^ n3) begin
        run <= 1'b1;
        pcnt <= 16'(PROG_CYC - 1);
      end else if (run) begin
        if (pcnt == 16'h0000) begin
          run <= 1'b0;
          done_tgl <= ~done_tgl;
        end else begin
          pcnt <= pcnt - 16'h0001;
        end
      end
    end
  end

  property p_glitch;
    @(posedge ref_clk) disable iff (!rstn)
    $changed(filt[0]) |-> $past(sy3[0], 1) == filt[0] && $past(sy3[0], 2) == filt[0];
  endproperty
  a_glitch: assert property (p_glitch) else $error("short pulse passed");

  property p_nomatch;
    @(posedge ref_clk) disable iff (!rstn)
    (state == icp_pkg::ST_ADDR && scl_fall && !stop_det && !start_det &&
     bitcnt == icp_pkg::BITS_PER_BYTE && shreg[7:1] != icp_pkg::OWN_ADDR)
    |=> state == icp_pkg::ST_IDLE && !sda_oe;
  endproperty
  a_nomatch: assert property (p_nomatch) else $error("acked foreign address");

  property p_match;
    @(posedge ref_clk) disable iff (!rstn)
    (state == icp_pkg::ST_ADDR && scl_fall && !stop_det && !start_det && booted &&
     bitcnt == icp_pkg::BITS_PER_BYTE && shreg[7:1] == icp_pkg::OWN_ADDR)
    |=> sda_oe && state == icp_pkg::ST_AACK;
  endproperty
  a_match: assert property (p_match) else $error("own address not acked");

  property p_sda_hold;
    @(posedge ref_clk) disable iff (!rstn)
    $changed(sda_oe) && !$past(stop_det) && !$past(start_det) |-> !filt[0];
  endproperty
  a_sda_hold: assert property (p_sda_hold) else $error("data moved with clock high");

  property p_stop;
    @(posedge ref_clk) disable iff (!rstn)
    stop_det |=> state == icp_pkg::ST_IDLE && !sda_oe ##1 !mem_open;
  endproperty
  a_stop: assert property (p_stop) else $error("stop not honoured");

  property p_nack;
    @(posedge ref_clk) disable iff (!rstn)
    (state == icp_pkg::ST_RACK && scl_rise && filt[1] && !stop_det && !start_det)
    |=> state == icp_pkg::ST_IDLE [*2];
  endproperty
  a_nack: assert property (p_nack) else $error("read continued after nack");

  property p_ptr_inc;
    @(posedge ref_clk) disable iff (!rstn)
    wr_stb |-> ptr == wr_addr + icp_pkg::BYTE_ONE;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer not advanced");

  property p_count;
    @(posedge ref_clk) disable iff (!rstn)
    done_ev |=> prog_count == $past(prog_count) + icp_pkg::BYTE_ONE && !prog_busy;
  endproperty
  a_count: assert property (p_count) else $error("program count wrong");

  property p_hide;
    @(posedge ref_clk) disable iff (!rstn)
    prog_busy |-> ee_view == icp_pkg::RST_BYTE;
  endproperty
  a_hide: assert property (p_hide) else $error("eeprom visible while busy");

  // The pointer moves one edge after the read strobe, so look there
  property p_busy_addr;
    @(posedge ref_clk) disable iff (!rstn)
    (prog_busy && rd_stb && rd_addr == icp_pkg::OFS_EEDATA) |=> $stable(mem_addr);
  endproperty
  a_busy_addr: assert property (p_busy_addr) else $error("busy read moved pointer");

  property p_launch;
    @(posedge ref_clk) disable iff (!rstn)
    (wr_stb && wr_addr == icp_pkg::OFS_MCTL && wr_data[icp_pkg::MCTL_PROG] &&
     unlock != icp_pkg::UNLOCK_KEY && !prog_busy) |=> !prog_busy;
  endproperty
  a_launch: assert property (p_launch) else $error("program without key");

  property p_boot;
    @(posedge ref_clk) disable iff (!rstn)
    !booted |=> regs[0] == $past(eeprom[0]);
  endproperty
  a_boot: assert property (p_boot) else $error("boot load missing");

  property p_copy;
    @(posedge ref_clk) disable iff (!rstn)
    (wr_stb && !prog_busy && wr_addr == icp_pkg::OFS_MCTL && wr_data[icp_pkg::MCTL_COPY])
    |=> sram[0] == $past(regs[0]);
  endproperty
  a_copy: assert property (p_copy) else $error("register copy missed");
endmodule

// [sim/icp_ctl_model.sv]
// Bus controller model standing on the far side of the serial target port.
// Assumes a pull-up on the data wire; the bench resolves the wire level.
`timescale 1ns/1ps
module icp_ctl_model (
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_m
);
  int q;
  logic glitch;

  // Idle bus: both lines released, clock still between frames
  initial begin
    q = 8;
    glitch = 1'b0;
    scl = 1'b1;
    sda_m = 1'b1;
  end

  task automatic wait_c(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // START or repeated START, clock left low
  task automatic sta();
    sda_m <= 1'b1;
    wait_c(q);
    scl <= 1'b1;
    wait_c(q);
    sda_m <= 1'b0;
    wait_c(q);
    scl <= 1'b0;
  endtask

  // STOP on the pulse after the last acknowledge
  task automatic sto();
    wait_c(q);
    sda_m <= 1'b0;
    wait_c(q);
    scl <= 1'b1;
    wait_c(q);
    sda_m <= 1'b1;
    wait_c(2 * q);
  endtask

  // One clock pulse; data moves only while the clock is low
  task automatic bit_cyc(input logic b, output logic s);
    wait_c(q);
    if (glitch) begin
      scl <= 1'b1; // Single 40 ns spike, shorter than the filter
      wait_c(1);
      scl <= 1'b0;
      wait_c(1);
    end
    sda_m <= b;
    wait_c(q);
    scl <= 1'b1;
    wait_c(q);
    s = sda_line;
    wait_c(q);
    scl <= 1'b0;
  endtask

  // n bits MSB first; the ninth pulse only for a whole byte
  task automatic wbits(input logic [7:0] d, input int n, output logic ack);
    logic s;
    ack = 1'b1;
    for (int i = 7; i > 7 - n; i--) bit_cyc(d[i], s);
    if (n == 8) bit_cyc(1'b1, ack);
  endtask

  // Reads a byte; low answers it, high ends the read
  task automatic rb(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, d[i]);
    bit_cyc(last, s);
  endtask
endmodule

// [sim/i2c_config_port_with_nvm_access_bench.sv]
// Self-checking bench for the serial target port with memory access.
// Assumes the controller model drives the bus; open-drain wire resolved here.
`timescale 1ns/1ps
module i2c_config_port_with_nvm_access_bench;
  localparam int PROG = 4000;
  localparam int LIMIT = 90000;
  logic ref_clk;
  logic nvm_clk;
  logic rstn;
  logic scl;
  logic sda_m;
  logic sda_o;
  logic sda_oe;
  logic boot_done;
  wire sda_line;
  int fails = 0;
  int n_tests = 0;
  int seed = 32'he158;
  int cyc = 0;

  // Wire-AND of both drivers, pull-up when released
  assign sda_line = sda_m & (sda_oe ? sda_o : 1'b1);

  icp_target #(.MEM_N(icp_pkg::MEM_N_DEF), .PROG_CYC(PROG)) uut (
    .ref_clk(ref_clk), .rstn(rstn), .nvm_clk(nvm_clk), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe), .boot_done(boot_done));
  icp_ctl_model m (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda_m(sda_m));

  // Clocks, unrelated in phase
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  initial begin
    nvm_clk = 1'b0;
    #7;
    forever #24 nvm_clk = ~nvm_clk;
  end

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fails++;
      end_of_test();
    end
  end

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask

  // Control readback: stored bits plus busy flag
  function automatic logic [7:0] exp_ctl(input logic [7:0] w, input logic busy);
    return (w & icp_pkg::MCTL_WMASK) | (8'(busy) << icp_pkg::MCTL_BUSY);
  endfunction

  // START, own address with write, register pointer byte
  task automatic addr(input logic [7:0] p);
    logic a;
    m.sta();
    m.wbits({icp_pkg::OWN_ADDR, 1'b0}, 8, a);
    chk1("address ack", 1'b0, a);
    m.wbits(p, 8, a);
    chk1("pointer ack", 1'b0, a);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
    logic a;
    addr(p);
    foreach (d[i]) begin
      m.wbits(d[i], 8, a);
      chk1("data ack", 1'b0, a);
    end
    m.sto();
  endtask
  // Pointer write, repeated START, read, NACK on the last byte
  task automatic rd(input logic [7:0] p, input logic [7:0] e[$], input string nm);
    logic a;
    logic [7:0] d;
    addr(p);
    m.sta();
    m.wbits({icp_pkg::OWN_ADDR, 1'b1}, 8, a);
    chk1("read address ack", 1'b0, a);
    foreach (e[i]) begin
      m.rb(i == e.size() - 1, d);
      chk8(nm, e[i], d);
    end
    m.wait_c(8);
    chk1("data released", 1'b0, sda_oe);
    m.sto();
  endtask
  // One memory session: pointer once, then one access per restart
  task automatic mem(input logic [7:0] r, input logic [7:0] base, input logic wrn,
      input logic [7:0] d[$], input string nm);
    logic a;
    logic [7:0] g;
    addr(icp_pkg::OFS_MADDR);
    m.wbits(base, 8, a);
    foreach (d[i]) begin
      addr(r);
      if (wrn) begin
        m.wbits(d[i], 8, a);
        chk1("memory data ack", 1'b0, a);
      end else begin
        m.sta();
        m.wbits({icp_pkg::OWN_ADDR, 1'b1}, 8, a);
        m.rb(1'b1, g);
        chk8(nm, d[i], g);
      end
    end
    m.sto();
  endtask

  initial begin
    logic [7:0] q[$];
    logic [7:0] w[$];
    logic [7:0] v;
    logic a;
    int k;
    rstn = 1'b0;
    repeat (10) @(posedge ref_clk);
    chk1("boot during reset", 1'b0, boot_done);
    chk1("oe during reset", 1'b0, sda_oe);
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk1("boot done", 1'b1, boot_done);
    // Foreign addresses, one a single bit off
    for (k = 0; k < 3; k++) begin
      v = (k == 0) ? 8'h58 : 8'($random(seed));
      if (v[6:0] == icp_pkg::OWN_ADDR) v[0] = ~v[0];
      m.sta();
      m.wbits({v[6:0], 1'b0}, 8, a);
      chk1("foreign ack", 1'b1, a);
      m.wbits(8'($random(seed)), 8, a);
      chk1("foreign silent", 1'b1, a);
      m.sto();
    end
    // Block write and read back
    repeat (4) q.push_back(8'($random(seed)));
    wr(8'h40, q);
    rd(8'h40, q, "block");
    // Slow write across pointer wrap, fast read
    repeat (3) w.push_back(8'($random(seed)));
    m.q = 63;
    wr(8'hFE, w);
    m.q = 7;
    rd(8'hFE, w, "wrap");
    m.q = 8;
    // Spikes on the clock line must not add bits
    v = 8'($random(seed));
    m.glitch = 1'b1;
    wr(8'h50, '{v});
    m.glitch = 1'b0;
    rd(8'h50, '{v}, "glitch");
    // Partial byte then STOP is discarded
    addr(8'h50);
    m.wbits(~v, 4, a);
    m.sto();
    rd(8'h50, '{v}, "partial");
    // Read-only and mixed bits
    wr(icp_pkg::OFS_PCOUNT, '{8'($random(seed))});
    rd(icp_pkg::OFS_PCOUNT, '{icp_pkg::RST_BYTE}, "count ro");
    wr(icp_pkg::OFS_MCTL, '{8'hFF});
    rd(icp_pkg::OFS_MCTL, '{exp_ctl(8'hFF, 1'b0)}, "ctl mixed");
    // Copy of the first 64 registers into SRAM, four read back
    wr(8'h00, q);
    wr(icp_pkg::OFS_MCTL, '{8'h01 << icp_pkg::MCTL_COPY});
    mem(icp_pkg::OFS_SRDATA, 8'h00, 1'b0, q, "sram copy");
    mem(icp_pkg::OFS_SRDATA, 8'h08, 1'b1, w, "");
    mem(icp_pkg::OFS_SRDATA, 8'h08, 1'b0, w, "sram write");
    // Unlocked programming, busy meanwhile, then count and EEPROM contents after it
    wr(icp_pkg::OFS_UNLOCK, '{icp_pkg::UNLOCK_KEY});
    wr(icp_pkg::OFS_MCTL, '{icp_pkg::BYTE_ONE});
    rd(icp_pkg::OFS_MCTL, '{exp_ctl(icp_pkg::BYTE_ONE, 1'b1)}, "busy");
    k = 0;
    do begin
      addr(icp_pkg::OFS_MCTL);
      m.sta();
      m.wbits({icp_pkg::OWN_ADDR, 1'b1}, 8, a);
      m.rb(1'b1, v);
      m.sto();
      k++;
    end while (v[icp_pkg::MCTL_BUSY] && k < 20);
    chk1("busy cleared", 1'b0, v[icp_pkg::MCTL_BUSY]);
    rd(icp_pkg::OFS_PCOUNT, '{icp_pkg::BYTE_ONE}, "count");
    mem(icp_pkg::OFS_EEDATA, 8'h00, 1'b0, q, "eeprom");
    // Relocked: program request ignored
    wr(icp_pkg::OFS_UNLOCK, '{icp_pkg::LOCK_VAL});
    wr(icp_pkg::OFS_MCTL, '{icp_pkg::BYTE_ONE});
    rd(icp_pkg::OFS_MCTL, '{exp_ctl(icp_pkg::BYTE_ONE, 1'b0)}, "locked");
    rd(icp_pkg::OFS_PCOUNT, '{icp_pkg::BYTE_ONE}, "count held");
    // Second program: bytes already stored must still read zero while busy
    wr(icp_pkg::OFS_UNLOCK, '{icp_pkg::UNLOCK_KEY});
    wr(icp_pkg::OFS_MCTL, '{icp_pkg::BYTE_ONE});
    mem(icp_pkg::OFS_EEDATA, 8'h00, 1'b0, '{icp_pkg::RST_BYTE, icp_pkg::RST_BYTE},
        "ee hidden");
    end_of_test();
  end
endmodule
